// ---- lss_regs.vh ----
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the display scan controller.
// Assumes: Byte addresses are four times the register index.
// Notes:   Definitions only.
`ifndef LSS_REGS_VH
`define LSS_REGS_VH

// ==========================================================================
// Register indices and address width
// ==========================================================================
`define LSS_IDX_IRQ_STATUS 8'hae
`define LSS_IDX_SCAN_RUN 8'haf
`define LSS_IDX_DISP_CTRL 8'hb1
`define LSS_IDX_MODE_CFG 8'hb2
`define LSS_IDX_IRQ_MASK 8'hc0
`define LSS_IDX_SCAN_WIDTH 8'hb3
`define LSS_IDX_GPIO_COM 8'hc1
`define LSS_ADDR_W 10

// ==========================================================================
// Field positions
// ==========================================================================
`define LSS_BIT_LED_FLAG 0
`define LSS_BIT_LCD_FLAG 1
`define LSS_BIT_RUN 0
`define LSS_BIT_COM_LOCK 0
`define LSS_BIT_REPEAT 1
`define LSS_BIT_TYPE 2
`define LSS_DUTY_LSB 3
`define LSS_DUTY_MSB 5
`define LSS_BIT_PINS_EN 6
`define LSS_BIT_LED_STYLE 7

// ==========================================================================
// Reset values
// ==========================================================================
`define LSS_RST_REG8 8'h00

// ==========================================================================
// Timing: one scan slot is (width+1) ticks of one microsecond base.
// ==========================================================================
`define LSS_CLK_MHZ 100
`define LSS_TICK_US 1
`define LSS_TICK_CYC (`LSS_CLK_MHZ * `LSS_TICK_US)

`endif

// ---- lss_scan_ctrl.v ----
// Purpose: Control, status and pin sequencer of an LCD / LED matrix scanner.
// Assumes: AXI4-Lite slave, 32-bit data, registers in low byte of a word.
// Notes:   One clock, synchronous active-high reset.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`include "lss_regs.vh"

module lss_scan_ctrl (
    // Clock and reset
    input wire clk,
    input wire reset,
    // AXI4-Lite write address and data
    input wire [`LSS_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [`LSS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Display pins
    output wire [7:0] comOut,
    output wire [7:0] comOe,
    output wire [27:0] segOut,
    output wire [27:0] segOe,
    // Interrupt and status
    output wire irq,
    output wire scanActive
);

    // ======================================================================
    // Register storage
    // ======================================================================
    reg [7:0] statusQ;
    reg [7:0] maskQ;
    reg runQ;
    reg [7:0] dispQ;
    reg [7:0] modeQ;
    reg [7:0] widthQ;
    reg [7:0] gpioQ;
    reg awHeldQ;
    reg wHeldQ;
    reg [`LSS_ADDR_W-1:0] awAddrQ;
    reg [31:0] wDataQ;
    reg [3:0] wStrbQ;
    reg bValidQ;
    reg [1:0] bRespQ;
    reg rValidQ;
    reg [31:0] rDataQ;
    reg [1:0] rRespQ;
    // One-cycle pulse at the end of a full pass, read by the run register.
    reg passEnd;

    // Decoded configuration fields.
    wire pinsEn = dispQ[`LSS_BIT_PINS_EN];
    wire ledSel = dispQ[`LSS_BIT_TYPE];
    wire repeatSel = dispQ[`LSS_BIT_REPEAT];
    wire comLock = dispQ[`LSS_BIT_COM_LOCK];
    wire [2:0] duty = dispQ[`LSS_DUTY_MSB:`LSS_DUTY_LSB];
    wire dotMode = modeQ[`LSS_BIT_LED_STYLE];

    // ======================================================================
    // AXI4-Lite handshake
    // ======================================================================
    // Address and data are latched in either order; the write fires when
    // both are held or taken that cycle and no response is pending.
    assign s_axi_awready = !awHeldQ && !bValidQ;
    assign s_axi_wready = !wHeldQ && !bValidQ;
    assign s_axi_bvalid = bValidQ;
    assign s_axi_bresp = bRespQ;
    assign s_axi_arready = !rValidQ;
    assign s_axi_rvalid = rValidQ;
    assign s_axi_rdata = rDataQ;
    assign s_axi_rresp = rRespQ;

    wire [`LSS_ADDR_W-1:0] wrAddr = s_axi_awvalid && s_axi_awready ?
        s_axi_awaddr : awAddrQ;
    wire [31:0] wrData = s_axi_wvalid && s_axi_wready ? s_axi_wdata : wDataQ;
    wire [3:0] wrStrb = s_axi_wvalid && s_axi_wready ? s_axi_wstrb : wStrbQ;
    wire haveAw = awHeldQ || (s_axi_awvalid && s_axi_awready);
    wire haveW = wHeldQ || (s_axi_wvalid && s_axi_wready);
    wire wrFire = haveAw && haveW && !bValidQ;
    wire [7:0] wrIdx = wrAddr[`LSS_ADDR_W-1:2];
    wire wrByte = wrFire && wrStrb[0];
    wire wrStatus = wrByte && wrIdx == `LSS_IDX_IRQ_STATUS;
    wire wrRun = wrByte && wrIdx == `LSS_IDX_SCAN_RUN;
    wire [7:0] rdIdx = s_axi_araddr[`LSS_ADDR_W-1:2];
    wire rdFire = s_axi_arvalid && s_axi_arready;

    // Decode whether a write or read index maps to a register.
    function known;
        input [7:0] idx;
        begin
            known = idx == `LSS_IDX_IRQ_STATUS || idx == `LSS_IDX_SCAN_RUN ||
                idx == `LSS_IDX_DISP_CTRL || idx == `LSS_IDX_MODE_CFG ||
                idx == `LSS_IDX_IRQ_MASK || idx == `LSS_IDX_SCAN_WIDTH ||
                idx == `LSS_IDX_GPIO_COM;
        end
    endfunction

    // Channel bookkeeping and write response.
    always @(posedge clk) begin
        if (reset) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            awAddrQ <= {`LSS_ADDR_W{1'b0}};
            wDataQ <= 32'h0;
            wStrbQ <= 4'h0;
            bValidQ <= 1'b0;
            bRespQ <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeldQ <= 1'b0;
                wHeldQ <= 1'b0;
                bValidQ <= 1'b1;
                bRespQ <= known(wrIdx) ? 2'h0 : 2'h2;
            end else begin
                awHeldQ <= haveAw;
                wHeldQ <= haveW;
                if (bValidQ && s_axi_bready) begin
                    bValidQ <= 1'b0;
                end
            end
        end
    end

    // Read data path; unmapped addresses answer SLVERR with zero data.
    always @(posedge clk) begin
        if (reset) begin
            rValidQ <= 1'b0;
            rDataQ <= 32'h0;
            rRespQ <= 2'h0;
        end else if (rdFire) begin
            rValidQ <= 1'b1;
            rRespQ <= known(rdIdx) ? 2'h0 : 2'h2;
            case (rdIdx)
                `LSS_IDX_IRQ_STATUS: rDataQ <= {24'h0, statusQ};
                `LSS_IDX_SCAN_RUN: rDataQ <= {31'h0, runQ};
                `LSS_IDX_DISP_CTRL: rDataQ <= {24'h0, dispQ};
                `LSS_IDX_MODE_CFG: rDataQ <= {24'h0, modeQ};
                `LSS_IDX_IRQ_MASK: rDataQ <= {24'h0, maskQ};
                `LSS_IDX_SCAN_WIDTH: rDataQ <= {24'h0, widthQ};
                `LSS_IDX_GPIO_COM: rDataQ <= {24'h0, gpioQ};
                default: rDataQ <= 32'h0;
            endcase
        end else if (rValidQ && s_axi_rready) begin
            rValidQ <= 1'b0;
        end
    end

    // ======================================================================
    // Configuration registers
    // ======================================================================
    // Read-write registers, low byte lane only; run self-clears unless repeat is set; unused bits read 0; mode, width and GPIO keep all eight.
    always @(posedge clk) begin
        if (reset) begin
            runQ <= 1'b0;
            dispQ <= `LSS_RST_REG8;
            modeQ <= `LSS_RST_REG8;
            maskQ <= `LSS_RST_REG8;
            widthQ <= `LSS_RST_REG8;
            gpioQ <= `LSS_RST_REG8;
        end else begin
            if (wrRun) begin
                runQ <= wrData[`LSS_BIT_RUN];
            end else if (passEnd && !repeatSel) begin
                runQ <= 1'b0;
            end
            if (wrByte && wrIdx == `LSS_IDX_DISP_CTRL) begin
                dispQ <= {1'b0, wrData[6:0]};
            end
            if (wrByte && wrIdx == `LSS_IDX_MODE_CFG) begin
                modeQ <= wrData[7:0];
            end
            if (wrByte && wrIdx == `LSS_IDX_IRQ_MASK) begin
                maskQ <= {6'h0, wrData[1:0]};
            end
            if (wrByte && wrIdx == `LSS_IDX_SCAN_WIDTH) begin
                widthQ <= wrData[7:0];
            end
            if (wrByte && wrIdx == `LSS_IDX_GPIO_COM) begin
                gpioQ <= wrData[7:0];
            end
        end
    end

    // ======================================================================
    // Scan sequencer
    // ======================================================================
    reg [6:0] tickCntQ;
    reg [7:0] slotCntQ;
    reg [3:0] phaseQ;
    localparam [6:0] TICK_LAST = `LSS_TICK_CYC - 1;

    // Number of COM phases in one pass for the current mode.
    reg [3:0] numPhase;
    reg [3:0] firstPhase;
    always @* begin
        numPhase = 4'd4;
        firstPhase = 4'd0;
        if (!ledSel) begin
            case (duty)
                3'h1: numPhase = 4'd8;
                3'h3: numPhase = 4'd5;
                3'h4: numPhase = 4'd6;
                3'h5: numPhase = 4'd6;
                default: numPhase = 4'd4;
            endcase
        end else if (dotMode) begin
            numPhase = {2'b00, duty[1:0]} + 4'd4;
            if (duty[2] && duty[1:0] == 2'b00) begin
                firstPhase = 4'd3;
            end
        end else begin
            numPhase = 4'd8;
        end
    end

    wire scanOn = runQ;
    wire tick = tickCntQ == TICK_LAST;
    wire slotEnd = tick && slotCntQ == widthQ;
    wire lastPhase = phaseQ == numPhase - 4'd1;

    // Slot timer and phase counter.
    // A stopped scan holds every counter at zero, so each start begins
    // a fresh pass at the first phase.
    always @(posedge clk) begin
        if (reset || !scanOn) begin
            tickCntQ <= 7'h0;
            slotCntQ <= 8'h0;
            phaseQ <= 4'h0;
            passEnd <= 1'b0;
        end else begin
            passEnd <= 1'b0;
            tickCntQ <= tick ? 7'h0 : tickCntQ + 7'h1;
            if (tick) begin
                slotCntQ <= slotEnd ? 8'h0 : slotCntQ + 8'h1;
            end
            if (slotEnd) begin
                if (lastPhase) begin
                    phaseQ <= 4'h0;
                    passEnd <= 1'b1;
                end else begin
                    phaseQ <= phaseQ + 4'h1;
                end
            end
        end
    end

    // ======================================================================
    // Pin drive
    // ======================================================================
    wire [3:0] activeCom = (phaseQ + firstPhase) & 4'h7;
    // Row-column mode has eight phases per pass; a SEG conducts in phases
    // 0 to n, which gives it n+1 eighths of the pass.
    wire rowCol = ledSel && !dotMode;
    wire segOnTime = rowCol ? phaseQ[2:0] <= duty : 1'b1;
    reg [7:0] comDrv;
    reg [7:0] comEn;
    reg [27:0] segDrv;
    reg [27:0] segEn;
    // LCD modes enable only the COM pins that the duty code uses.
    always @* begin
        comDrv = 8'h0;
        comDrv[activeCom[2:0]] = 1'b1;
        comEn = 8'hff;
        segDrv = {28{segOnTime && (rowCol || !phaseQ[0])}};
        segEn = {4'h0, {24{1'b1}}};
        if (!ledSel) begin
            comEn = 8'hff >> (4'd8 - numPhase);
            case (duty)
                3'h2: segEn = {28{1'b1}};
                3'h3: segEn = {3'h7, 1'b0, {24{1'b1}}};
                3'h4: segEn = {2'h3, 2'h0, {24{1'b1}}};
                3'h5: segEn = {2'h3, 2'h0, {24{1'b1}}};
                default: segEn = {4'h0, {24{1'b1}}};
            endcase
        end else begin
            segEn = {20'h0, 8'hff};
        end
    end

    // Pin master switch and COM lock override.
    assign comOut = comLock ? gpioQ : (scanOn ? comDrv : 8'h0);
    assign comOe = comLock ? 8'hff : (pinsEn ? comEn : 8'h0);
    assign segOut = scanOn ? segDrv & segEn : 28'h0;
    assign segOe = pinsEn ? segEn : 28'h0;
    assign scanActive = scanOn;

    // ======================================================================
    // Status flags and interrupt
    // ======================================================================
    // Pass end sets; a zero write or a run write clears; set wins.
    wire setLcd = passEnd && !ledSel;
    wire setLed = passEnd && ledSel;
    always @(posedge clk) begin
        if (reset) begin
            statusQ <= `LSS_RST_REG8;
        end else begin
            if (setLcd) begin
                statusQ[`LSS_BIT_LCD_FLAG] <= 1'b1;
            end else if (wrRun ||
                (wrStatus && !wrData[`LSS_BIT_LCD_FLAG])) begin
                statusQ[`LSS_BIT_LCD_FLAG] <= 1'b0;
            end
            if (setLed) begin
                statusQ[`LSS_BIT_LED_FLAG] <= 1'b1;
            end else if (wrRun ||
                (wrStatus && !wrData[`LSS_BIT_LED_FLAG])) begin
                statusQ[`LSS_BIT_LED_FLAG] <= 1'b0;
            end
        end
    end

    assign irq = |(statusQ & maskQ);

endmodule

// ---- lss_panel_model.sv ----
// Purpose: Passive panel model that records which scan pins were driven.
// Assumes: Pins are sampled on the core clock.
// Notes:   The bench clears the record before each pass.
`timescale 1ns/1ns
// ============================================================
// Panel model
// ============================================================
module lss_panel_model (
    // Clock and clear
    input wire clk,
    input wire clr,
    // Scan pins
    input wire [7:0] comOe,
    input wire [27:0] segOe,
    input wire [27:0] segOut,
    // Observations
    output reg [7:0] comSeen,
    output reg [27:0] segSeen,
    output reg [15:0] segCnt
);
    // Accumulate driven pins and count cycles with any SEG lit.
    always @(posedge clk) begin
        if (clr) begin
            comSeen <= 8'h00;
            segSeen <= 28'h0000000;
            segCnt <= 16'h0000;
        end else begin
            comSeen <= comSeen | comOe;
            segSeen <= segSeen | segOe;
            segCnt <= segCnt + {15'h0000, |segOut};
        end
    end
endmodule

// ---- lss_scan_ctrl_assertions.sv ----
// Purpose: Bus and pin assertions for the display scan controller.
// Assumes: Write address and data are offered in the same cycle.
// Notes:   Shadows track the control, GPIO and last addressed registers.
`timescale 1ns/1ns
`include "lss_regs.vh"
// ============================================================
// Checker
// ============================================================
module lss_scan_ctrl_assertions (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Register bus
    input wire [`LSS_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire [`LSS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    // Pins and status
    input wire [7:0] comOut,
    input wire [7:0] comOe,
    input wire [27:0] segOe,
    input wire irq,
    input wire scanActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire [7:0] wIdx = s_axi_awaddr[9:2];
    wire wLow = wrTake && s_axi_wstrb[0];
    reg [7:0] ctrl_q, gpio_q, bIdx_q, rIdx_q;
    reg run_q;
    // True for every register index that the block decodes.
    function mapped(input [7:0] i);
        begin
            mapped = i == `LSS_IDX_IRQ_STATUS || i == `LSS_IDX_SCAN_RUN ||
                i == `LSS_IDX_DISP_CTRL || i == `LSS_IDX_MODE_CFG ||
                i == `LSS_IDX_IRQ_MASK || i == `LSS_IDX_SCAN_WIDTH ||
                i == `LSS_IDX_GPIO_COM;
        end
    endfunction
    // Shadow copies are updated on the same edge as the registers.
    always @(posedge clk) begin
        if (reset) begin
            ctrl_q <= 8'h00;
            gpio_q <= 8'h00;
            bIdx_q <= 8'h00;
            rIdx_q <= 8'h00;
            run_q <= 1'b0;
        end else begin
            if (wrTake) bIdx_q <= wIdx;
            if (arTake) rIdx_q <= s_axi_araddr[9:2];
            if (wLow && wIdx == `LSS_IDX_DISP_CTRL) ctrl_q <= s_axi_wdata[7:0];
            if (wLow && wIdx == `LSS_IDX_GPIO_COM) gpio_q <= s_axi_wdata[7:0];
            if (wLow && wIdx == `LSS_IDX_SCAN_RUN) run_q <= s_axi_wdata[0];
        end
    end
    a_write_resp: assert property (wrTake |=> s_axi_bvalid &&
        s_axi_bresp == (mapped(bIdx_q) ? 2'b00 : 2'b10))
        else $error("write response wrong");
    a_read_resp: assert property (arTake |=> s_axi_rvalid &&
        s_axi_rresp == (mapped(rIdx_q) ? 2'b00 : 2'b10))
        else $error("read response wrong");
    a_ctrl_readback: assert property (arTake &&
        s_axi_araddr[9:2] == `LSS_IDX_DISP_CTRL |=>
        s_axi_rdata == {25'h0000000, ctrl_q[6:0]})
        else $error("control readback wrong");
    a_run_follows: assert property (wLow && wIdx == `LSS_IDX_SCAN_RUN
        |=> scanActive == run_q) else $error("scan state not run bit");
    a_pins_off: assert property (!ctrl_q[6] |-> segOe == 28'h0000000 &&
        (ctrl_q[0] || comOe == 8'h00)) else $error("pins driven while off");
    a_com_lock: assert property (ctrl_q[0] && ctrl_q[6] |->
        comOut == gpio_q && comOe == 8'hff) else $error("COM lock ignored");
    a_irq_clear: assert property (wrTake && wIdx == `LSS_IDX_SCAN_RUN
        |=> !irq) else $error("run write left irq set");
    a_single_pass: assert property ($fell(scanActive) &&
        !$past(wrTake) |-> !ctrl_q[1]) else $error("cycle scan stopped");
    c_pass_end: cover property ($fell(scanActive));
    c_irq_seen: cover property (irq);
    c_com_lock: cover property (ctrl_q[0] && ctrl_q[6]);
endmodule
bind lss_scan_ctrl lss_scan_ctrl_assertions chk (.clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .comOut(comOut), .comOe(comOe),
    .segOe(segOe), .irq(irq), .scanActive(scanActive));

// ---- lss_scan_ctrl_bench.sv ----
// Purpose: Register-level bench for the display scan controller.
// Assumes: Scan width stays 0, so one slot lasts 100 clock cycles.
// Notes:   Pass length is rounded to whole slots before comparing.
`timescale 1ns/1ns
`include "lss_regs.vh"
// ============================================================
// Bench
// ============================================================
module lss_scan_ctrl_bench;
    reg clk = 1'b0, reset = 1'b1, clr = 1'b0;
    reg [9:0] awAddr = 10'h000, arAddr = 10'h000;
    reg [31:0] wData = 32'h00000000;
    reg awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    reg arValid = 1'b0, rReady = 1'b0;
    wire awReady, wReady, bValid, arReady, rValid, irq, scanActive;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    wire [7:0] comOut, comOe, comSeen;
    wire [27:0] segOut, segOe, segSeen;
    wire [15:0] segCnt;
    integer n_errors, n_tests, cyc, i;
    localparam [31:0] LCD_PH = 32'h44665484;
    localparam [63:0] LCD_PINS = 64'h0f0fffffffffff0f;
    lss_scan_ctrl uut (.clk(clk), .reset(reset), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .comOut(comOut), .comOe(comOe),
        .segOut(segOut), .segOe(segOe), .irq(irq), .scanActive(scanActive));
    lss_panel_model panel (.clk(clk), .clr(clr), .comOe(comOe),
        .segOe(segOe), .segOut(segOut), .comSeen(comSeen),
        .segSeen(segSeen),
        .segCnt(segCnt));
    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;
    // Compares one value and counts the outcome.
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    // One bus write; address and data are released as each is taken.
    task wr(input [7:0] ix, input [7:0] d, input [1:0] er);
        integer k;
        begin
            @(posedge clk);
            awAddr <= {ix, 2'b00};
            wData <= {24'h000000, d};
            awValid <= 1'b1;
            wValid <= 1'b1;
            bReady <= 1'b1;
            for (k = 0; k < 50 && bValid !== 1'b1; k = k + 1) begin
                @(posedge clk);
                if (awValid && awReady) awValid <= 1'b0;
                if (wValid && wReady) wValid <= 1'b0;
            end
            bReady <= 1'b0;
            chk({30'h0, bResp}, {30'h0, er});
        end
    endtask
    // One bus read; data and response are taken at the rvalid edge.
    task rd(input [7:0] ix, input [7:0] d, input [1:0] er);
        integer k;
        begin
            @(posedge clk);
            arAddr <= {ix, 2'b00};
            arValid <= 1'b1;
            rReady <= 1'b1;
            for (k = 0; k < 50 && rValid !== 1'b1; k = k + 1) begin
                @(posedge clk);
                if (arValid && arReady) arValid <= 1'b0;
            end
            rReady <= 1'b0;
            chk({rResp, rData}, {er, 24'h000000, d});
        end
    endtask
    // Configures while stopped, starts a pass and times it.
    task pass(input [7:0] cfg);
        begin
            clr <= 1'b1;
            wr(`LSS_IDX_DISP_CTRL, cfg, 2'b00);
            clr <= 1'b0;
            wr(`LSS_IDX_SCAN_RUN, 8'h01, 2'b00);
            cyc = 0;
            while (scanActive === 1'b1 && cyc < 3000) begin
                @(posedge clk);
                cyc = cyc + 1;
            end
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task stop_test;
        begin
            $display("tests %0d errors %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Watchdog cuts a hang short after about 100000 cycles.
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        stop_test;
    end
    // Main sequence of register-level tests.
    initial begin
        n_errors = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(`LSS_IDX_IRQ_STATUS, 8'h00, 2'b00);
        rd(`LSS_IDX_SCAN_RUN, 8'h00, 2'b00);
        rd(`LSS_IDX_DISP_CTRL, 8'h00, 2'b00);
        rd(`LSS_IDX_MODE_CFG, 8'h00, 2'b00);
        rd(8'h00, 8'h00, 2'b10);
        wr(8'h00, 8'h00, 2'b10);
        wr(`LSS_IDX_DISP_CTRL, 8'hff, 2'b00);
        rd(`LSS_IDX_DISP_CTRL, 8'h7f, 2'b00);
        for (i = 0; i < 8; i = i + 1) begin
            pass({2'b01, i[2:0], 3'b000});
            chk((cyc + 50) / 100, LCD_PH[4*i+:4]);
            chk(comSeen | {segSeen[27:24], 4'h0}, LCD_PINS[8*i+:8]);
            rd(`LSS_IDX_IRQ_STATUS, 8'h02, 2'b00);
            rd(`LSS_IDX_SCAN_RUN, 8'h00, 2'b00);
        end
        wr(`LSS_IDX_IRQ_STATUS, 8'hff, 2'b00);
        rd(`LSS_IDX_IRQ_STATUS, 8'h02, 2'b00);
        wr(`LSS_IDX_IRQ_MASK, 8'h02, 2'b00);
        chk(irq, 1'b1);
        wr(`LSS_IDX_IRQ_MASK, 8'h01, 2'b00);
        chk(irq, 1'b0);
        wr(`LSS_IDX_IRQ_STATUS, 8'h00, 2'b00);
        rd(`LSS_IDX_IRQ_STATUS, 8'h00, 2'b00);
        pass(8'h00);
        chk({4'h0, segSeen} | comSeen, 32'h0);
        wr(`LSS_IDX_SCAN_RUN, 8'h00, 2'b00);
        rd(`LSS_IDX_IRQ_STATUS, 8'h00, 2'b00);
        wr(`LSS_IDX_MODE_CFG, 8'h80, 2'b00);
        for (i = 0; i < 5; i = i + 1) begin
            pass({2'b01, i[2:0], 3'b100});
            chk((cyc + 50) / 100, 4 + i[1:0]);
            rd(`LSS_IDX_IRQ_STATUS, 8'h01, 2'b00);
        end
        wr(`LSS_IDX_MODE_CFG, 8'h00, 2'b00);
        for (i = 0; i < 8; i = i + 1) begin
            pass({2'b01, i[2:0], 3'b100});
            chk((segCnt * 8 + cyc / 2) / cyc, i + 1);
        end
        wr(`LSS_IDX_DISP_CTRL, 8'h42, 2'b00);
        wr(`LSS_IDX_SCAN_RUN, 8'h01, 2'b00);
        repeat (1500) @(posedge clk);
        chk(scanActive, 1'b1);
        wr(`LSS_IDX_SCAN_RUN, 8'h00, 2'b00);
        chk(scanActive, 1'b0);
        rd(`LSS_IDX_IRQ_STATUS, 8'h00, 2'b00);
        wr(`LSS_IDX_GPIO_COM, 8'ha5, 2'b00);
        wr(`LSS_IDX_DISP_CTRL, 8'h41, 2'b00);
        wr(`LSS_IDX_SCAN_RUN, 8'h01, 2'b00);
        chk({comOe, comOut}, 16'hffa5);
        wr(`LSS_IDX_SCAN_RUN, 8'h00, 2'b00);
        stop_test;
    end
endmodule
